// ===== hdl/smrd_defines.vh
`ifndef SMRD_DEFINES_VH
`define SMRD_DEFINES_VH

// ****************************************************************
// Register indices
// ****************************************************************
`define SMRD_IDX_SAVE_BASE 32'hc001_0111
`define SMRD_IDX_WIN_BASE 32'hc001_0112
`define SMRD_IDX_WIN_MASK 32'hc001_0113
`define SMRD_IDX_HW_CFG 32'hc001_0015

// ****************************************************************
// Field positions
// ****************************************************************
`define SMRD_ADDR_HI 39
`define SMRD_ADDR_LO 17
`define SMRD_VAR_DRAM_HI 14
`define SMRD_VAR_DRAM_LO 12
`define SMRD_FIX_DRAM_HI 10
`define SMRD_FIX_DRAM_LO 8
`define SMRD_VAR_IOWC_BIT 5
`define SMRD_FIX_IOWC_BIT 4
`define SMRD_VAR_CLOSE_BIT 3
`define SMRD_FIX_CLOSE_BIT 2
`define SMRD_VAR_EN_BIT 1
`define SMRD_FIX_EN_BIT 0
`define SMRD_LOCK_BIT 0
`define SMRD_ENTRY_DIS_BIT 1
`define SMRD_EXIT_DIS_BIT 2

// ****************************************************************
// Fixed window and memory types
// ****************************************************************
`define SMRD_FIX_LO 40'h00_000a_0000
`define SMRD_FIX_HI 40'h00_000b_ffff
`define SMRD_MT_UC 3'h0
`define SMRD_MT_WC 3'h1

// ****************************************************************
// Routing codes and reset values
// ****************************************************************
`define SMRD_RT_MTRR 2'h0
`define SMRD_RT_DRAM 2'h1
`define SMRD_RT_IO 2'h2
`define SMRD_RST_64 64'h0000_0000_0000_0000
`define SMRD_RST_SAVE_BASE 32'h0003_0000

`endif

// ===== hdl/smrd_var_match.v
`timescale 1ns/1ps
`default_nettype none
`include "smrd_defines.vh"

// Variable window compare: masked address equals masked base
module smrd_var_match #(
   parameter AW = 40
) (
   input wire [AW-1:0] addr_in,
   input wire [22:0] base_in,
   input wire [22:0] mask_in,
   input wire enable_in,
   output wire hit_out
);
   // ****************************************************************
   // Compare
   // ****************************************************************
   // Low 17 bits never take part, so the window is 128 KB aligned
   assign hit_out = enable_in &&
      ((addr_in[`SMRD_ADDR_HI:`SMRD_ADDR_LO] & mask_in) == (base_in & mask_in));
endmodule
`default_nettype wire

// ===== hdl/smrd_special_cycle.v
`timescale 1ns/1ps
`default_nettype none

// Edge detector for mode transitions, one-cycle special-cycle pulses
module smrd_special_cycle (
   input wire clk_in,
   input wire rst_in,
   input wire in_smm_in,
   input wire entry_dis_in,
   input wire exit_dis_in,
   output reg entry_cycle_out,
   output reg exit_cycle_out
);
   reg smm_prev_reg;

   // ****************************************************************
   // Transition pulses
   // ****************************************************************
   // Disable bits only gate the pulse; mode tracking continues
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         smm_prev_reg <= 1'b0;
         entry_cycle_out <= 1'b0;
         exit_cycle_out <= 1'b0;
      end else begin
         smm_prev_reg <= in_smm_in;
         entry_cycle_out <= in_smm_in && !smm_prev_reg && !entry_dis_in;
         exit_cycle_out <= !in_smm_in && smm_prev_reg && !exit_dis_in;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/smrd_range_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "smrd_defines.vh"

module smrd_range_decoder #(
   parameter AW = 40
) (
   input wire clk_in,
   input wire rst_in,
   // Register access port
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [31:0] reg_idx_in,
   input wire [63:0] reg_wdata_in,
   output reg [63:0] reg_rdata_out,
   output reg reg_rvalid_out,
   // Core address stream
   input wire acc_valid_in,
   input wire [AW-1:0] acc_addr_in,
   input wire in_smm_in,
   input wire acc_is_data_in,
   // Decoded access
   output reg dec_valid_out,
   output reg [AW-1:0] dec_addr_out,
   output reg [1:0] dec_route_out,
   output reg [2:0] dec_mem_type_out,
   // Special cycles
   output reg entry_cycle_out,
   output reg exit_cycle_out,
   // State visible to the core
   output reg config_lock_bit_out
);
   // ****************************************************************
   // Configuration state
   // ****************************************************************
   reg [31:0] save_area_base_reg;
   reg [22:0] win_base_reg;
   reg [22:0] win_mask_reg;
   reg [2:0] var_window_dram_type_reg;
   reg [2:0] fixed_window_dram_type_reg;
   reg var_window_io_wc_select_reg;
   reg fixed_window_io_wc_select_reg;
   reg var_close_reg;
   reg fixed_close_reg;
   reg var_enable_reg;
   reg fixed_window_enable_reg;
   reg config_lock_reg;
   reg entry_cycle_disable_reg;
   reg exit_cycle_disable_reg;

   wire wr_save;
   wire wr_base;
   wire wr_mask;
   wire wr_hw;
   wire cfg_open;

   // Write strobes per register; unknown indices match none
   assign wr_save = reg_wr_in && (reg_idx_in == `SMRD_IDX_SAVE_BASE);
   assign wr_base = reg_wr_in && (reg_idx_in == `SMRD_IDX_WIN_BASE);
   assign wr_mask = reg_wr_in && (reg_idx_in == `SMRD_IDX_WIN_MASK);
   assign wr_hw = reg_wr_in && (reg_idx_in == `SMRD_IDX_HW_CFG);
   // Locked fields drop writes silently, no error is raised
   assign cfg_open = !config_lock_reg;

   // Save-area base
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         save_area_base_reg <= `SMRD_RST_SAVE_BASE;
      end else if (wr_save && cfg_open) begin
         save_area_base_reg <= reg_wdata_in[31:0];
      end
   end

   // Variable window base; low 17 bits are never stored
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         win_base_reg <= 23'h00_0000;
      end else if (wr_base && cfg_open) begin
         win_base_reg <= reg_wdata_in[`SMRD_ADDR_HI:`SMRD_ADDR_LO];
      end
   end

   // Close bits stay writable so a locked handler can still reach I/O
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         var_close_reg <= 1'b0;
         fixed_close_reg <= 1'b0;
      end else if (wr_mask) begin
         var_close_reg <= reg_wdata_in[`SMRD_VAR_CLOSE_BIT];
         fixed_close_reg <= reg_wdata_in[`SMRD_FIX_CLOSE_BIT];
      end
   end

   // Remaining mask fields freeze once the lock is set
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         win_mask_reg <= 23'h00_0000;
         var_window_dram_type_reg <= 3'h0;
         fixed_window_dram_type_reg <= 3'h0;
         var_window_io_wc_select_reg <= 1'b0;
         fixed_window_io_wc_select_reg <= 1'b0;
         var_enable_reg <= 1'b0;
         fixed_window_enable_reg <= 1'b0;
      end else if (wr_mask && cfg_open) begin
         win_mask_reg <= reg_wdata_in[`SMRD_ADDR_HI:`SMRD_ADDR_LO];
         var_window_dram_type_reg <=
            reg_wdata_in[`SMRD_VAR_DRAM_HI:`SMRD_VAR_DRAM_LO];
         fixed_window_dram_type_reg <=
            reg_wdata_in[`SMRD_FIX_DRAM_HI:`SMRD_FIX_DRAM_LO];
         var_window_io_wc_select_reg <= reg_wdata_in[`SMRD_VAR_IOWC_BIT];
         fixed_window_io_wc_select_reg <= reg_wdata_in[`SMRD_FIX_IOWC_BIT];
         var_enable_reg <= reg_wdata_in[`SMRD_VAR_EN_BIT];
         fixed_window_enable_reg <= reg_wdata_in[`SMRD_FIX_EN_BIT];
      end
   end

   // Lock and special-cycle disables; a set lock also freezes itself
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         config_lock_reg <= 1'b0;
         entry_cycle_disable_reg <= 1'b0;
         exit_cycle_disable_reg <= 1'b0;
      end else if (wr_hw && cfg_open) begin
         // Lock only ever sets here; reset alone clears it
         config_lock_reg <= reg_wdata_in[`SMRD_LOCK_BIT];
         entry_cycle_disable_reg <= reg_wdata_in[`SMRD_ENTRY_DIS_BIT];
         exit_cycle_disable_reg <= reg_wdata_in[`SMRD_EXIT_DIS_BIT];
      end
   end

   // ****************************************************************
   // Register read
   // ****************************************************************
   reg [63:0] rdata_next;

   // Reserved bits read as zero
   always @* begin
      rdata_next = `SMRD_RST_64;
      case (reg_idx_in)
         `SMRD_IDX_SAVE_BASE: begin
            rdata_next[31:0] = save_area_base_reg;
         end
         `SMRD_IDX_WIN_BASE: begin
            rdata_next[`SMRD_ADDR_HI:`SMRD_ADDR_LO] = win_base_reg;
         end
         `SMRD_IDX_WIN_MASK: begin
            rdata_next[`SMRD_ADDR_HI:`SMRD_ADDR_LO] = win_mask_reg;
            rdata_next[`SMRD_VAR_DRAM_HI:`SMRD_VAR_DRAM_LO] = var_window_dram_type_reg;
            rdata_next[`SMRD_FIX_DRAM_HI:`SMRD_FIX_DRAM_LO] = fixed_window_dram_type_reg;
            rdata_next[`SMRD_VAR_IOWC_BIT] = var_window_io_wc_select_reg;
            rdata_next[`SMRD_FIX_IOWC_BIT] = fixed_window_io_wc_select_reg;
            rdata_next[`SMRD_VAR_CLOSE_BIT] = var_close_reg;
            rdata_next[`SMRD_FIX_CLOSE_BIT] = fixed_close_reg;
            rdata_next[`SMRD_VAR_EN_BIT] = var_enable_reg;
            rdata_next[`SMRD_FIX_EN_BIT] = fixed_window_enable_reg;
         end
         `SMRD_IDX_HW_CFG: begin
            rdata_next[`SMRD_LOCK_BIT] = config_lock_reg;
            rdata_next[`SMRD_ENTRY_DIS_BIT] = entry_cycle_disable_reg;
            rdata_next[`SMRD_EXIT_DIS_BIT] = exit_cycle_disable_reg;
         end
         default: begin
            rdata_next = `SMRD_RST_64;
         end
      endcase
   end

   // Read answer stands one cycle; idle cycles show zero
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= `SMRD_RST_64;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rdata_out <= reg_rd_in ? rdata_next : `SMRD_RST_64;
         reg_rvalid_out <= reg_rd_in;
      end
   end

   // Lock mirror for the core, one cycle behind the register
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         config_lock_bit_out <= 1'b0;
      end else begin
         config_lock_bit_out <= config_lock_reg;
      end
   end

   // ****************************************************************
   // Window hits
   // ****************************************************************
   wire fix_hit = fixed_window_enable_reg &&
      (acc_addr_in >= `SMRD_FIX_LO) && (acc_addr_in <= `SMRD_FIX_HI);
   wire var_hit;

   // Variable window compare lives in its own module
   smrd_var_match #(
      .AW(AW)
   ) u_var_match (
      .addr_in(acc_addr_in),
      .base_in(win_base_reg),
      .mask_in(win_mask_reg),
      .enable_in(var_enable_reg),
      .hit_out(var_hit)
   );

   // ****************************************************************
   // Route and memory type
   // ****************************************************************
   reg [1:0] route_next;
   reg [2:0] type_next;
   wire fix_to_dram;
   wire var_to_dram;

   // Close bits divert only data accesses made inside the mode
   assign fix_to_dram = in_smm_in && !(fixed_close_reg && acc_is_data_in);
   assign var_to_dram = in_smm_in && !(var_close_reg && acc_is_data_in);

   // Fixed window checked first; overlaps are software's problem
   always @* begin
      route_next = `SMRD_RT_MTRR;
      type_next = `SMRD_MT_UC;
      if (fix_hit) begin
         if (fix_to_dram) begin
            route_next = `SMRD_RT_DRAM;
            type_next = fixed_window_dram_type_reg;
         end else begin
            // Outside mode the window never reaches DRAM or caches
            route_next = `SMRD_RT_IO;
            type_next = fixed_window_io_wc_select_reg ? `SMRD_MT_WC : `SMRD_MT_UC;
         end
      end else if (var_hit) begin
         if (var_to_dram) begin
            route_next = `SMRD_RT_DRAM;
            type_next = var_window_dram_type_reg;
         end else begin
            route_next = `SMRD_RT_IO;
            type_next = var_window_io_wc_select_reg ? `SMRD_MT_WC : `SMRD_MT_UC;
         end
      end
   end

   // One cycle decode latency
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         dec_valid_out <= 1'b0;
         dec_addr_out <= {AW{1'b0}};
         dec_route_out <= `SMRD_RT_MTRR;
         dec_mem_type_out <= `SMRD_MT_UC;
      end else begin
         dec_valid_out <= acc_valid_in;
         dec_addr_out <= acc_addr_in;
         dec_route_out <= route_next;
         dec_mem_type_out <= type_next;
      end
   end

   // ****************************************************************
   // Special cycles
   // ****************************************************************
   wire entry_pulse;
   wire exit_pulse;

   // Mode edge detector; its pulses are registered again below
   smrd_special_cycle u_special_cycle (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .in_smm_in(in_smm_in),
      .entry_dis_in(entry_cycle_disable_reg),
      .exit_dis_in(exit_cycle_disable_reg),
      .entry_cycle_out(entry_pulse),
      .exit_cycle_out(exit_pulse)
   );

   // Re-registered so the top outputs come from flops here
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         entry_cycle_out <= 1'b0;
         exit_cycle_out <= 1'b0;
      end else begin
         entry_cycle_out <= entry_pulse;
         exit_cycle_out <= exit_pulse;
      end
   end
endmodule
`default_nettype wire

// ===== test/smrd_range_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************************
// Port-level checks of the window decoder
// ******************************************
module smrd_range_checker #(
   parameter AW = 40
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_idx_in,
   input wire logic [63:0] reg_wdata_in,
   input wire logic reg_rvalid_out,
   input wire logic acc_valid_in,
   input wire logic [AW-1:0] acc_addr_in,
   input wire logic in_smm_in,
   input wire logic acc_is_data_in,
   input wire logic dec_valid_out,
   input wire logic [AW-1:0] dec_addr_out,
   input wire logic [1:0] dec_route_out,
   input wire logic [2:0] dec_mem_type_out,
   input wire logic entry_cycle_out,
   input wire logic exit_cycle_out,
   input wire logic config_lock_bit_out
);
   reg [63:0] m_reg;
   reg [63:0] b_reg;
   reg [2:0] h_reg;
   wire fixh;
   wire varh;
   wire cl;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   // Shadow of the config; once locked only the close bits follow writes
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         m_reg <= 64'h0;
         b_reg <= 64'h0;
         h_reg <= 3'h0;
      end else if (reg_wr_in && reg_idx_in == 32'hc001_0113) begin
         m_reg <= h_reg[0] ? {m_reg[63:4], reg_wdata_in[3:2], m_reg[1:0]} : reg_wdata_in;
      end else if (reg_wr_in && reg_idx_in == 32'hc001_0112 && !h_reg[0]) begin
         b_reg <= reg_wdata_in;
      end else if (reg_wr_in && reg_idx_in == 32'hc001_0015 && !h_reg[0]) begin
         h_reg <= reg_wdata_in[2:0];
      end
   end
   // Fixed window wins on overlap, so the variable hit excludes it
   assign fixh = acc_valid_in && m_reg[0] && acc_addr_in >= 40'ha_0000 && acc_addr_in <= 40'hb_ffff;
   assign varh = acc_valid_in && m_reg[1] && !fixh &&
      ((acc_addr_in[39:17] ^ b_reg[39:17]) & m_reg[39:17]) == 23'h0;
   assign cl = in_smm_in && acc_is_data_in;
   a_fixed_out_io: assert property (fixh && !in_smm_in |=> dec_route_out == 2'h2 && dec_mem_type_out == {2'h0, m_reg[4]}) else $error("fixed window outside mode misrouted");
   a_fixed_in_dram: assert property (fixh && in_smm_in && !(m_reg[2] && acc_is_data_in) |=> dec_route_out == 2'h1 && dec_mem_type_out == m_reg[10:8]) else $error("fixed window in mode misrouted");
   a_fixed_close: assert property (fixh && m_reg[2] && cl |=> dec_route_out == 2'h2 && dec_mem_type_out == {2'h0, m_reg[4]}) else $error("fixed close ignored");
   a_var_out_io: assert property (varh && !in_smm_in |=> dec_route_out == 2'h2 && dec_mem_type_out == {2'h0, m_reg[5]}) else $error("variable window outside mode misrouted");
   a_var_in_dram: assert property (varh && in_smm_in && !(m_reg[3] && acc_is_data_in) |=> dec_route_out == 2'h1 && dec_mem_type_out == m_reg[14:12]) else $error("variable window in mode misrouted");
   a_var_close: assert property (varh && m_reg[3] && cl |=> dec_route_out == 2'h2 && dec_mem_type_out == {2'h0, m_reg[5]}) else $error("variable close ignored");
   a_miss_mtrr: assert property (acc_valid_in && !fixh && !varh |=> dec_route_out == 2'h0 && dec_mem_type_out == 3'h0) else $error("miss not passed on");
   a_addr_pass: assert property (acc_valid_in |=> dec_valid_out && dec_addr_out == $past(acc_addr_in)) else $error("access not passed through");
   a_entry_cycle: assert property ($rose(in_smm_in) && !h_reg[1] |-> ##2 entry_cycle_out) else $error("entry cycle missing");
   a_exit_cycle: assert property ($fell(in_smm_in) && !h_reg[2] |-> ##2 exit_cycle_out) else $error("exit cycle missing");
   a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read not answered");
   a_lock_held: assert property (h_reg[0] |=> config_lock_bit_out) else $error("lock dropped");
   c_fixed: cover property (fixh && cl);
   c_var: cover property (varh && !in_smm_in);
   c_lock: cover property ($rose(config_lock_bit_out));
endmodule
bind smrd_range_decoder smrd_range_checker #(.AW(AW)) u_smrd_range_checker (.clk_in, .rst_in,
   .reg_wr_in, .reg_rd_in, .reg_idx_in, .reg_wdata_in, .reg_rvalid_out, .acc_valid_in,
   .acc_addr_in, .in_smm_in, .acc_is_data_in, .dec_valid_out, .dec_addr_out, .dec_route_out,
   .dec_mem_type_out, .entry_cycle_out, .exit_cycle_out, .config_lock_bit_out);
`default_nettype wire

// ===== test/smrd_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************************
// Core side: mode level and access stream
// ******************************************
module smrd_core_model (
   input wire logic clk_in,
   output logic acc_valid_out,
   output logic [39:0] acc_addr_out,
   output logic in_smm_out,
   output logic acc_is_data_out
);
   initial begin
      acc_valid_out = 1'b0;
      acc_addr_out = 40'h0;
      in_smm_out = 1'b0;
      acc_is_data_out = 1'b0;
   end
   // Mode and access kind go with every access
   task set_mode(input logic s);
      @(negedge clk_in);
      in_smm_out = s;
   endtask
   // Held across the sampling edge; stale address inverted once released
   task present(input logic [39:0] a, input logic d);
      @(negedge clk_in);
      acc_valid_out = 1'b1;
      acc_addr_out = a;
      acc_is_data_out = d;
      @(posedge clk_in);
      @(negedge clk_in);
      acc_valid_out = 1'b0;
      acc_addr_out = ~a;
   endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************************
// Decoder bench
// ******************************************
module testbench;
   localparam logic [31:0] ix_s = 32'hc001_0111;
   localparam logic [31:0] ix_b = 32'hc001_0112;
   localparam logic [31:0] ix_m = 32'hc001_0113;
   localparam logic [31:0] ix_h = 32'hc001_0015;
   logic clk_in, rst_in, reg_wr_in, reg_rd_in, acc_valid_in, in_smm_in, acc_is_data_in;
   logic [31:0] reg_idx_in;
   logic [63:0] reg_wdata_in, reg_rdata_out;
   logic [39:0] acc_addr_in, dec_addr_out;
   logic [1:0] dec_route_out;
   logic [2:0] dec_mem_type_out;
   logic reg_rvalid_out, dec_valid_out, entry_cycle_out, exit_cycle_out, config_lock_bit_out;
   int errors = 0;
   int n_compared = 0;
   smrd_range_decoder u_smrd_range_decoder (.clk_in(clk_in), .rst_in(rst_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_idx_in(reg_idx_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .reg_rvalid_out(reg_rvalid_out), .acc_valid_in(acc_valid_in), .acc_addr_in(acc_addr_in),
      .in_smm_in(in_smm_in), .acc_is_data_in(acc_is_data_in), .dec_valid_out(dec_valid_out),
      .dec_addr_out(dec_addr_out), .dec_route_out(dec_route_out),
      .dec_mem_type_out(dec_mem_type_out), .entry_cycle_out(entry_cycle_out),
      .exit_cycle_out(exit_cycle_out), .config_lock_bit_out(config_lock_bit_out));
   smrd_core_model u_smrd_core_model (.clk_in(clk_in), .acc_valid_out(acc_valid_in),
      .acc_addr_out(acc_addr_in), .in_smm_out(in_smm_in), .acc_is_data_out(acc_is_data_in));
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   task test_done;
      $display("errors=%0d n_compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [63:0] g, input logic [63:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr(input logic [31:0] i, input logic [63:0] d);
      @(negedge clk_in);
      reg_wr_in = 1'b1;
      reg_idx_in = i;
      reg_wdata_in = d;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
   endtask
   // Answer is registered: look just after the taking edge
   task rd(input logic [31:0] i, input logic [63:0] e);
      @(negedge clk_in);
      reg_rd_in = 1'b1;
      reg_idx_in = i;
      @(posedge clk_in);
      #1;
      chk(reg_rdata_out, e);
      chk({63'h0, reg_rvalid_out}, 64'h1);
      @(negedge clk_in);
      reg_rd_in = 1'b0;
   endtask
   // Expected e packs route in bits 4:3 and memory type in bits 2:0
   task ac(input logic [39:0] a, input logic s, input logic d, input logic [4:0] e);
      u_smrd_core_model.set_mode(s);
      u_smrd_core_model.present(a, d);
      chk({59'h0, dec_route_out, dec_mem_type_out}, {59'h0, e});
      chk({24'h0, dec_addr_out}, {24'h0, a});
      chk({63'h0, dec_valid_out}, 64'h1);
   endtask
   task t_regs;
      rd(ix_m, 64'h0);
      rd(ix_s, 64'h3_0000);
      wr(ix_s, '1);
      rd(ix_s, 64'hffff_ffff);
      wr(ix_b, '1);
      rd(ix_b, 64'hff_fffe_0000);
      wr(ix_m, '1);
      rd(ix_m, 64'hff_fffe_773f);
      rd(32'h0000_0001, 64'h0);
   endtask
   task t_fixed;
      wr(ix_m, 64'h511);
      ac(40'ha_0000, 1'b0, 1'b1, 5'h11);
      ac(40'hb_ffff, 1'b1, 1'b1, 5'h0d);
      ac(40'hb_ffff, 1'b0, 1'b0, 5'h11);
      ac(40'h9_ffff, 1'b0, 1'b1, 5'h00);
      ac(40'hc_0000, 1'b1, 1'b1, 5'h00);
      wr(ix_m, 64'h505);
      ac(40'hb_0000, 1'b1, 1'b1, 5'h10);
      ac(40'hb_0000, 1'b1, 1'b0, 5'h0d);
      wr(ix_m, 64'h0);
      ac(40'ha_0000, 1'b0, 1'b1, 5'h00);
   endtask
   task t_var;
      wr(ix_b, 64'h10_1234);
      wr(ix_m, 64'hfffc_3022);
      ac(40'h10_0000, 1'b0, 1'b1, 5'h11);
      ac(40'h13_ffff, 1'b1, 1'b1, 5'h0b);
      ac(40'h14_0000, 1'b1, 1'b1, 5'h00);
      ac(40'h0f_ffff, 1'b1, 1'b1, 5'h00);
      wr(ix_m, 64'hfffc_302a);
      ac(40'h12_0000, 1'b1, 1'b1, 5'h11);
      ac(40'h12_0000, 1'b1, 1'b0, 5'h0b);
      wr(ix_m, 64'hfffc_3020);
      ac(40'h10_0000, 1'b0, 1'b1, 5'h00);
   endtask
   // Pairs of entry then exit under no, entry and exit suppression
   task t_cycles;
      logic [2:0] hv;
      logic [1:0] n;
      for (int j = 0; j < 6; j++) begin
         hv = 3'(j / 2 * 2);
         if (j % 2 == 0) wr(ix_h, {61'h0, hv});
         n = 2'h0;
         u_smrd_core_model.set_mode(j % 2 == 0);
         repeat (5) begin
            @(posedge clk_in);
            #1;
            n = n | {entry_cycle_out, exit_cycle_out};
         end
         chk({62'h0, n}, {62'h0, (j % 2 == 0) ? {!hv[1], 1'b0} : {1'b0, !hv[2]}});
      end
   endtask
   task t_lock;
      wr(ix_m, 64'h507);
      wr(ix_h, 64'h1);
      wr(ix_h, 64'h0);
      rd(ix_h, 64'h1);
      wr(ix_m, 64'h0);
      rd(ix_m, 64'h503);
      wr(ix_b, 64'h0);
      rd(ix_b, 64'h10_0000);
      wr(ix_s, 64'h0);
      rd(ix_s, 64'hffff_ffff);
      chk({63'h0, config_lock_bit_out}, 64'h1);
      @(negedge clk_in);
      rst_in = 1'b1;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      rst_in = 1'b0;
      wr(ix_m, 64'h4);
      rd(ix_m, 64'h4);
      rd(ix_h, 64'h0);
      rd(ix_s, 64'h3_0000);
   endtask
   initial begin
      #20000;
      errors++;
      test_done;
   end
   initial begin
      rst_in = 1'b1;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_idx_in = 32'h0;
      reg_wdata_in = 64'h0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      rst_in = 1'b0;
      t_regs;
      t_fixed;
      t_var;
      t_cycles;
      t_lock;
      test_done;
   end
endmodule
`default_nettype wire
